// ==== logic/perf_profile_pkg.sv ====
// holds constants, types and the register map of the performance counter block
// assumes a 64-bit register port clocked by the core clock; nothing else
package perf_profile_pkg;

  // ==========================================================
  // register port geometry
  localparam int ADDR_W = 8; // byte address width
  localparam int DATA_W = 64; // argument and result word width

  // ==========================================================
  // register offsets, one 64-bit word each
  localparam logic [7:0] OFF_EVENT_SELECT = 8'h00; // mode and event pair
  localparam logic [7:0] OFF_COUNTERS = 8'h08; // read counters / write counters
  localparam logic [7:0] OFF_ENABLE_WRITE = 8'h10; // enable and write counters
  localparam logic [7:0] OFF_ENABLE = 8'h18; // set enables, read enables
  localparam logic [7:0] OFF_DISABLE = 8'h20; // clear enables
  localparam logic [7:0] OFF_PROFILE_STATUS = 8'h28; // profiled instruction status
  localparam logic [7:0] OFF_PROFILED_PC = 8'h30; // profiled pc register
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h38; // sticky event bits, read only
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h40; // write ones to clear
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h48; // interrupt enables

  // ==========================================================
  // field positions
  localparam int SEL_MODE_BIT = 4; // 1 profiling, 0 aggregate
  localparam int SEL_PAIR_LO = 2; // event pair field, 2 bits
  localparam int PAIR_W = 2; // width of the event pair field
  localparam int CNT_W = 20; // counter width
  localparam int CNT0_LO = 28; // counter 0 field low bit
  localparam int CNT1_LO = 6; // counter 1 field low bit
  localparam int SEL_CNT0_BIT = 0; // counter 0 select
  localparam int SEL_CNT1_BIT = 1; // counter 1 select
  localparam int NUM_CNT = 2; // number of counters
  localparam int STAT_TRAP_BIT = 39; // profiled instruction trapped
  localparam int STAT_MISP_BIT = 40; // mispredict trap
  localparam int IRQ_W = 3; // number of interrupt events
  localparam int IRQ_WRAP0_BIT = 0; // counter 0 wrapped
  localparam int IRQ_WRAP1_BIT = 1; // counter 1 wrapped
  localparam int IRQ_SAMPLE_BIT = 2; // profile sample captured

  // ==========================================================
  // reset values
  localparam logic RST_MODE = 1'b0; // aggregate mode
  localparam logic [1:0] RST_PAIR = 2'h0; // retired / cycles
  localparam logic [1:0] RST_ENABLE = 2'h0; // counters stopped
  localparam logic [2:0] RST_IRQ = 3'h0; // no events, all masked

  // ==========================================================
  // event pair encodings
  localparam logic [1:0] PAIR_RET_CYC = 2'h0; // c0 retired, c1 cycles
  localparam logic [1:0] PAIR_CYC_ALT = 2'h1; // c0 cycles, c1 delayed retire or none
  localparam logic [1:0] PAIR_RET_BC = 2'h2; // c0 retired, c1 backup cache misses
  localparam logic [1:0] PAIR_CYC_NONE = 2'h3; // c0 cycles, c1 idle

  // what a counter counts
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_CYCLE,
    SRC_RETIRE,
    SRC_DELAY,
    SRC_BCACHE
  } count_source_t;

  // one-cycle event pulses from the core
  typedef struct packed {
    logic retire; // an instruction retired
    logic retire_delay; // retire pointer advance was delayed
    logic bcache_miss; // backup cache miss or long probe latency
  } core_events_t;

  // report of one profiled instruction
  typedef struct packed {
    logic valid; // report present this cycle
    logic trap; // instruction trapped
    logic mispredict; // trap was a mispredict
    logic jump_class; // jump, subroutine, return or coroutine form
    logic [DATA_W-1:0] pc; // pc of the instruction
  } profile_report_t;

endpackage : perf_profile_pkg

// ==== logic/perf_event_counter.sv ====
// holds one loadable event counter with a wrap pulse
// assumes tick and load come from logic on the same clock
`timescale 1ns/1ps

module perf_event_counter #(
  parameter int WIDTH = perf_profile_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable, // counting allowed
  input wire logic tick, // one event this cycle
  input wire logic load, // load takes priority over tick
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] value,
  output logic wrap // one cycle after rolling over
);

  logic [WIDTH-1:0] next_value; // counter next value
  logic next_wrap; // roll-over next value

  // ==========================================================
  // next value: load, else count when enabled
  always_comb
  begin
    next_value = value;
    next_wrap = 1'b0;
    if (load)
    begin
      next_value = load_value;
    end
    else if (enable && tick)
    begin
      next_value = value + WIDTH'(1);
      next_wrap = &value;
    end
  end

  // registers only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      value <= '0;
      wrap <= 1'b0;
    end
    else
    begin
      value <= next_value;
      wrap <= next_wrap;
    end
  end

endmodule : perf_event_counter

// ==== logic/profile_sample_capture.sv ====
// holds the status word and pc of the last profiled instruction
// assumes reports come from the core on the same clock
`timescale 1ns/1ps

module profile_sample_capture (
  input wire logic clk,
  input wire logic resetn,
  input wire logic armed, // profiling mode selected
  input perf_profile_pkg::profile_report_t report,
  output logic [perf_profile_pkg::DATA_W-1:0] status_word,
  output logic [perf_profile_pkg::DATA_W-1:0] pc_word,
  output logic captured // one cycle after a capture
);

  logic [perf_profile_pkg::DATA_W-1:0] next_status_word; // status next value
  logic [perf_profile_pkg::DATA_W-1:0] next_pc_word; // pc next value
  logic next_captured; // capture pulse next value

  // ==========================================================
  // build the status word; reserved bits stay zero
  always_comb
  begin
    next_status_word = status_word;
    next_pc_word = pc_word;
    next_captured = 1'b0;
    if (armed && report.valid)
    begin
      next_status_word = '0;
      next_status_word[perf_profile_pkg::STAT_TRAP_BIT] = report.trap;
      // jump class mispredicts show only through the trap bit and the pc
      next_status_word[perf_profile_pkg::STAT_MISP_BIT] =
        report.trap && report.mispredict && !report.jump_class;
      next_pc_word = report.pc;
      next_captured = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_word <= '0;
      pc_word <= '0;
      captured <= 1'b0;
    end
    else
    begin
      status_word <= next_status_word;
      pc_word <= next_pc_word;
      captured <= next_captured;
    end
  end

endmodule : profile_sample_capture

// ==== logic/perf_counter_profile_unit.sv ====
// holds the top of the performance counter and profiling block
// assumes a register master on clk that never asserts both strobes at once,
// and core event pulses already on clk
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - bit 4 picks profiling or aggregate mode
// - profiling mode pairs set by bits 3-2
// - aggregate mode pairs set by bits 3-2
// - counter read places counter 0, counter 1
// - counter write loads only selected counters
// - enable-and-write enables and loads selected counters
// - status bit 39 marks a trapping instruction
// - status bit 40 marks mispredict trap
// - jump class mispredicts never set bit 40
// - error traps may hit any instruction
// - per-counter enable bit stops counting when clear
module perf_counter_profile_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [perf_profile_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [perf_profile_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [perf_profile_pkg::DATA_W-1:0] reg_rdata,
  input perf_profile_pkg::core_events_t core_events,
  input perf_profile_pkg::profile_report_t profile_report,
  output logic profiling_mode,
  output logic irq
);

  // ==========================================================
  // control state
  // written by software over the port; the sticky bits are also set by events
  logic [perf_profile_pkg::PAIR_W-1:0] event_pair; // selected event pair
  logic [perf_profile_pkg::NUM_CNT-1:0] counter_enable; // per counter enable
  logic [perf_profile_pkg::IRQ_W-1:0] irq_status; // sticky events
  logic [perf_profile_pkg::IRQ_W-1:0] irq_enable; // event mask
  logic next_profiling_mode; // mode next value
  logic [perf_profile_pkg::PAIR_W-1:0] next_event_pair; // pair next value
  logic [perf_profile_pkg::NUM_CNT-1:0] next_counter_enable; // enable next value
  logic [perf_profile_pkg::IRQ_W-1:0] next_irq_status; // status next value
  logic [perf_profile_pkg::IRQ_W-1:0] next_irq_enable; // mask next value
  logic [perf_profile_pkg::DATA_W-1:0] next_reg_rdata; // read data next value

  // ==========================================================
  // decoded accesses
  // one strobe raises at most one of these;
  // read-only or unmapped writes raise none
  logic wr_select; // event selection write
  logic wr_counters; // counter write
  logic wr_enable_write; // enable and write
  logic wr_enable; // enable set
  logic wr_disable; // enable clear
  logic wr_irq_clear; // sticky clear
  logic wr_irq_enable; // mask write
  logic [perf_profile_pkg::NUM_CNT-1:0] arg_select; // counter select bits

  // ==========================================================
  // counter side
  // arrays indexed by counter number
  perf_profile_pkg::count_source_t source [perf_profile_pkg::NUM_CNT]; // what each counts
  logic [perf_profile_pkg::NUM_CNT-1:0] tick; // per counter event
  logic [perf_profile_pkg::NUM_CNT-1:0] load; // per counter load
  logic [perf_profile_pkg::NUM_CNT-1:0] wrap; // per counter roll-over
  logic [perf_profile_pkg::CNT_W-1:0] load_value [perf_profile_pkg::NUM_CNT]; // load fields
  logic [perf_profile_pkg::CNT_W-1:0] count_value [perf_profile_pkg::NUM_CNT]; // live counts

  // ==========================================================
  // profiling capture side
  // last report, held until the next one
  logic [perf_profile_pkg::DATA_W-1:0] status_word; // last status word
  logic [perf_profile_pkg::DATA_W-1:0] pc_word; // last profiled pc
  logic captured; // capture pulse
  logic [perf_profile_pkg::IRQ_W-1:0] irq_events; // events this cycle

  // ==========================================================
  // write decode; reads need no decode beyond the mux
  // select bits come from every write word;
  // only load and enable strobes use them
  always_comb
  begin
    wr_select = reg_write && (reg_addr == perf_profile_pkg::OFF_EVENT_SELECT);
    wr_counters = reg_write && (reg_addr == perf_profile_pkg::OFF_COUNTERS);
    wr_enable_write = reg_write && (reg_addr == perf_profile_pkg::OFF_ENABLE_WRITE);
    wr_enable = reg_write && (reg_addr == perf_profile_pkg::OFF_ENABLE);
    wr_disable = reg_write && (reg_addr == perf_profile_pkg::OFF_DISABLE);
    wr_irq_clear = reg_write && (reg_addr == perf_profile_pkg::OFF_IRQ_CLEAR);
    wr_irq_enable = reg_write && (reg_addr == perf_profile_pkg::OFF_IRQ_ENABLE);
    arg_select[0] = reg_wdata[perf_profile_pkg::SEL_CNT0_BIT];
    arg_select[1] = reg_wdata[perf_profile_pkg::SEL_CNT1_BIT];
  end

  // ==========================================================
  // event pair to counter sources
  // both modes agree except on pair 01;
  // an undefined counter holds its value
  // so software never sees a drifting count
  always_comb
  begin
    source[0] = perf_profile_pkg::SRC_NONE;
    source[1] = perf_profile_pkg::SRC_NONE;
    unique case (event_pair)
      perf_profile_pkg::PAIR_RET_CYC:
      begin
        source[0] = perf_profile_pkg::SRC_RETIRE;
        source[1] = perf_profile_pkg::SRC_CYCLE;
      end
      perf_profile_pkg::PAIR_CYC_ALT:
      begin
        source[0] = perf_profile_pkg::SRC_CYCLE;
        // aggregate mode leaves counter 1 undefined: it holds still
        source[1] = profiling_mode ? perf_profile_pkg::SRC_DELAY
                                   : perf_profile_pkg::SRC_NONE;
      end
      perf_profile_pkg::PAIR_RET_BC:
      begin
        source[0] = perf_profile_pkg::SRC_RETIRE;
        source[1] = perf_profile_pkg::SRC_BCACHE;
      end
      perf_profile_pkg::PAIR_CYC_NONE:
      begin
        source[0] = perf_profile_pkg::SRC_CYCLE;
        source[1] = perf_profile_pkg::SRC_NONE;
      end
    endcase
  end

  // ==========================================================
  // one counter per channel with its source, load and field
  generate
    for (genvar i = 0; i < perf_profile_pkg::NUM_CNT; i++)
    begin : g_counter
      // low bit of this counter's field
      localparam int LO = (i == 0) ? perf_profile_pkg::CNT0_LO : perf_profile_pkg::CNT1_LO;

      // source to tick
      // a cycle source ticks on every edge
      always_comb
      begin
        unique case (source[i])
          perf_profile_pkg::SRC_CYCLE: tick[i] = 1'b1;
          perf_profile_pkg::SRC_RETIRE: tick[i] = core_events.retire;
          perf_profile_pkg::SRC_DELAY: tick[i] = core_events.retire_delay;
          perf_profile_pkg::SRC_BCACHE: tick[i] = core_events.bcache_miss;
          default: tick[i] = 1'b0;
        endcase
      end

      // only the selected counters load; other argument bits are ignored
      // a load while disabled still lands;
      // counting waits for the enable
      assign load[i] = (wr_counters || wr_enable_write) && arg_select[i];
      assign load_value[i] = reg_wdata[LO +: perf_profile_pkg::CNT_W];

      perf_event_counter #(
        .WIDTH(perf_profile_pkg::CNT_W)
      ) u_counter (
        .clk(clk),
        .resetn(resetn),
        .enable(counter_enable[i]),
        .tick(tick[i]),
        .load(load[i]),
        .load_value(load_value[i]),
        .value(count_value[i]),
        .wrap(wrap[i])
      );
    end
  endgenerate

  // ==========================================================
  // profiled instruction capture, armed only in profiling mode
  // aggregate-mode reports are dropped, so
  // the last profiling sample stays readable
  profile_sample_capture u_capture (
    .clk(clk),
    .resetn(resetn),
    .armed(profiling_mode),
    .report(profile_report),
    .status_word(status_word),
    .pc_word(pc_word),
    .captured(captured)
  );

  // ==========================================================
  // interrupt events
  // each is a one-cycle flop pulse, so a
  // sticky bit sees every event exactly once
  always_comb
  begin
    irq_events = '0;
    irq_events[perf_profile_pkg::IRQ_WRAP0_BIT] = wrap[0];
    irq_events[perf_profile_pkg::IRQ_WRAP1_BIT] = wrap[1];
    irq_events[perf_profile_pkg::IRQ_SAMPLE_BIT] = captured;
  end

  // level interrupt while an enabled sticky bit is set
  // drops only on a clear or a mask write
  assign irq = |(irq_status & irq_enable);

  // ==========================================================
  // control next values
  // set and clear of an enable sit at two
  // offsets, so they never meet in a cycle
  always_comb
  begin
    next_profiling_mode = profiling_mode;
    next_event_pair = event_pair;
    next_counter_enable = counter_enable;
    next_irq_enable = irq_enable;
    if (wr_select)
    begin
      next_profiling_mode = reg_wdata[perf_profile_pkg::SEL_MODE_BIT];
      next_event_pair = reg_wdata[perf_profile_pkg::SEL_PAIR_LO +: perf_profile_pkg::PAIR_W];
    end
    if (wr_enable || wr_enable_write)
    begin
      next_counter_enable = counter_enable | arg_select;
    end
    else if (wr_disable)
    begin
      next_counter_enable = counter_enable & ~arg_select;
    end
    if (wr_irq_enable)
    begin
      next_irq_enable = reg_wdata[perf_profile_pkg::IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    next_irq_status = irq_status;
    if (wr_irq_clear)
    begin
      next_irq_status = irq_status & ~reg_wdata[perf_profile_pkg::IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  // ==========================================================
  // read data, one cycle after the strobe and zero otherwise
  // the master samples only that cycle, so
  // the bus rests at zero in all others
  always_comb
  begin
    next_reg_rdata = '0;
    if (reg_read)
    begin
      unique case (reg_addr)
        perf_profile_pkg::OFF_EVENT_SELECT:
        begin
          next_reg_rdata[perf_profile_pkg::SEL_MODE_BIT] = profiling_mode;
          next_reg_rdata[perf_profile_pkg::SEL_PAIR_LO +: perf_profile_pkg::PAIR_W] = event_pair;
        end
        perf_profile_pkg::OFF_COUNTERS:
        begin
          next_reg_rdata[perf_profile_pkg::CNT0_LO +: perf_profile_pkg::CNT_W] = count_value[0];
          next_reg_rdata[perf_profile_pkg::CNT1_LO +: perf_profile_pkg::CNT_W] = count_value[1];
        end
        perf_profile_pkg::OFF_ENABLE:
        begin
          next_reg_rdata[perf_profile_pkg::SEL_CNT0_BIT] = counter_enable[0];
          next_reg_rdata[perf_profile_pkg::SEL_CNT1_BIT] = counter_enable[1];
        end
        perf_profile_pkg::OFF_PROFILE_STATUS: next_reg_rdata = status_word;
        perf_profile_pkg::OFF_PROFILED_PC: next_reg_rdata = pc_word;
        perf_profile_pkg::OFF_IRQ_STATUS: next_reg_rdata[perf_profile_pkg::IRQ_W-1:0] = irq_status;
        perf_profile_pkg::OFF_IRQ_ENABLE: next_reg_rdata[perf_profile_pkg::IRQ_W-1:0] = irq_enable;
        // write-only and unmapped offsets read zero
        default: next_reg_rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // registers only
  // control state clears here; counters and
  // the capture block reset in their modules
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      profiling_mode <= perf_profile_pkg::RST_MODE;
      event_pair <= perf_profile_pkg::RST_PAIR;
      counter_enable <= perf_profile_pkg::RST_ENABLE;
      irq_status <= perf_profile_pkg::RST_IRQ;
      irq_enable <= perf_profile_pkg::RST_IRQ;
      reg_rdata <= '0;
    end
    else
    begin
      profiling_mode <= next_profiling_mode;
      event_pair <= next_event_pair;
      counter_enable <= next_counter_enable;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : perf_counter_profile_unit

// ==== test/perf_counter_profile_unit_sva.sv ====
// holds port-level assertions for the performance counter block
// assumes binding onto the top module; one clock domain
`timescale 1ns/1ps

module perf_counter_profile_unit_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [63:0] reg_rdata,
  input perf_profile_pkg::core_events_t core_events,
  input perf_profile_pkg::profile_report_t profile_report,
  input wire logic profiling_mode,
  input wire logic irq
);
  // ==========================================
  // shared clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // mode follows bit 4 of an event-select write
  property p_mode;
    reg_write && reg_addr == 8'h00 |=> profiling_mode == $past(reg_wdata[4]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit mismatch");
  // event-select readback carries the mode
  property p_sel;
    reg_read && reg_addr == 8'h00 |=> reg_rdata[4] == $past(profiling_mode) && reg_rdata[63:5] == 59'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("select readback mismatch");
  // read data only in the cycle after a read
  property p_idle;
    !reg_read |=> reg_rdata == 64'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  // reserved counter word bits read zero
  property p_cnt;
    reg_read && reg_addr == 8'h08 |=> reg_rdata[63:48] == 16'h0 && reg_rdata[27:26] == 2'h0 && reg_rdata[5:0] == 6'h0;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter word reserved bits set");
  // status word keeps only bits 40 and 39
  property p_stat;
    reg_read && reg_addr == 8'h28 |=> reg_rdata[63:41] == 23'h0 && reg_rdata[38:0] == 39'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status reserved bits set");
  // mispredict only beside trap
  property p_misp;
    reg_read && reg_addr == 8'h28 |=> !reg_rdata[40] || reg_rdata[39];
  endproperty
  a_misp: assert property (p_misp) else $error("mispredict without trap");
  // jump class never flags a mispredict
  property p_jump;
    (profiling_mode && profile_report.valid && profile_report.jump_class) ##1 !profile_report.valid
      ##1 (reg_read && reg_addr == 8'h28 && !profile_report.valid) |=> !reg_rdata[40];
  endproperty
  a_jump: assert property (p_jump) else $error("jump class flagged mispredict");
  // trap bit follows the captured report
  property p_trap;
    (profiling_mode && profile_report.valid) ##1 !profile_report.valid
      ##1 (reg_read && reg_addr == 8'h28 && !profile_report.valid) |=> reg_rdata[39] == $past(profile_report.trap, 3);
  endproperty
  a_trap: assert property (p_trap) else $error("trap bit mismatch");
  // unmapped offsets read zero
  property p_unmap;
    reg_read && reg_addr > 8'h48 |=> reg_rdata == 64'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // all masked drops the interrupt
  property p_mask;
    reg_write && reg_addr == 8'h48 && reg_wdata[2:0] == 3'h0 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt while masked");
endmodule : perf_counter_profile_unit_sva

bind perf_counter_profile_unit perf_counter_profile_unit_sva u_sva (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .core_events(core_events), .profile_report(profile_report),
  .profiling_mode(profiling_mode), .irq(irq));

// ==== test/perf_counter_profile_unit_tb.sv ====
// holds the self-checking bench of the performance counter block
// assumes package, design and checker compiled before it
`timescale 1ns/1ps

module perf_counter_profile_unit_tb;
  // ==========================================
  // stimulus and observed signals
  logic clk = 1'b0; // core clock
  logic resetn = 1'b0; // reset, active low
  logic [7:0] reg_addr = 8'h00;
  logic [63:0] reg_wdata = 64'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [63:0] reg_rdata;
  perf_profile_pkg::core_events_t core_events = '0;
  perf_profile_pkg::profile_report_t profile_report = '0;
  logic profiling_mode;
  logic irq;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0; // hang guard

  // 40 ns clock
  always #20 clk = ~clk;

  perf_counter_profile_unit dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .core_events(core_events), .profile_report(profile_report),
    .profiling_mode(profiling_mode), .irq(irq));

  // ==========================================
  // shared tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // compare one value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [63:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // one-cycle core event pulse
  task automatic pulse(input logic [2:0] ev);
    @(posedge clk);
    core_events <= ev;
    @(posedge clk);
    core_events <= 3'h0;
  endtask : pulse

  // one profiled instruction report: trap, mispredict, jump class
  task automatic rep(input logic [2:0] tmj, input logic [63:0] pc);
    @(posedge clk);
    profile_report <= {1'b1, tmj, pc};
    @(posedge clk);
    profile_report <= '0;
  endtask : rep

  // counter deltas packed as c0, c1
  function automatic logic [63:0] dif(input logic [63:0] a, input logic [63:0] b);
    return {24'h0, b[47:28] - a[47:28], b[25:6] - a[25:6]};
  endfunction : dif

  // ==========================================
  // scenarios
  task automatic t_basic;
    logic [63:0] d;
    rd(8'h08, d);
    chk(d, 64'h0);
    wr(8'h00, 64'hFFFF_FFFF_FFFF_FFF3);
    rd(8'h00, d);
    chk(d, 64'h10);
    chk(profiling_mode, 1'b1);
    wr(8'h00, 64'h0);
    #1 chk(profiling_mode, 1'b0);
    wr(8'h08, {16'hFFFF, 20'hABCDE, 2'h3, 20'h12345, 6'h3D});
    rd(8'h08, d);
    chk(d, {16'h0, 20'hABCDE, 2'h0, 20'h0, 6'h0});
    wr(8'h08, {16'h0, 20'h11111, 2'h0, 20'h12345, 6'h02});
    rd(8'h08, d);
    chk(d, {16'h0, 20'hABCDE, 2'h0, 20'h12345, 6'h0});
    $display("basic test done");
  endtask : t_basic

  // every mode and pair, distinct pulse counts per source
  task automatic t_count;
    logic [63:0] a;
    logic [63:0] b;
    logic [19:0] e1;
    for (int m = 0; m < 2; m++)
      for (int p = 0; p < 4; p++)
      begin
        wr(8'h00, {59'h0, m[0], p[1:0], 2'h0});
        wr(8'h10, 64'h3);
        rd(8'h08, a);
        if (!p[0])
          chk(a[47:28], 20'h0);
        pulse(3'h4);
        repeat (2) pulse(3'h2);
        repeat (3) pulse(3'h1);
        rd(8'h08, b);
        case (p)
          0: e1 = 20'hE;
          1: e1 = m ? 20'h2 : 20'h0;
          2: e1 = 20'h3;
          default: e1 = 20'h0;
        endcase
        chk(dif(a, b), {24'h0, p[0] ? 20'hE : 20'h1, e1});
      end
    wr(8'h00, 64'h0);
    wr(8'h20, 64'h1);
    rd(8'h18, a);
    chk(a, 64'h2);
    rd(8'h08, a);
    pulse(3'h7);
    rd(8'h08, b);
    chk(dif(a, b), {24'h0, 20'h0, 20'h4});
    wr(8'h18, 64'h1);
    rd(8'h18, a);
    chk(a, 64'h3);
    wr(8'h20, 64'h3);
    $display("count test done");
  endtask : t_count

  // counter 1 wrap raises, masks and clears the interrupt
  task automatic t_wrap;
    logic [63:0] d;
    wr(8'h48, 64'h2);
    wr(8'h10, {38'h0, 20'hFFFFE, 6'h02});
    repeat (6) @(posedge clk);
    #1 chk(irq, 1'b1);
    rd(8'h38, d);
    chk(d, 64'h2);
    wr(8'h20, 64'h2);
    wr(8'h48, 64'h0);
    #1 chk(irq, 1'b0);
    wr(8'h48, 64'h2);
    #1 chk(irq, 1'b1);
    wr(8'h40, 64'h2);
    #1 chk(irq, 1'b0);
    rd(8'h38, d);
    chk(d, 64'h0);
    $display("wrap test done");
  endtask : t_wrap

  // profiled status for all trap, mispredict, jump class mixes
  task automatic t_profile;
    logic [63:0] d;
    rep(3'h6, 64'h100);
    rd(8'h28, d);
    chk(d, 64'h0);
    wr(8'h00, 64'h10);
    wr(8'h48, 64'h4);
    for (int i = 0; i < 8; i++)
    begin
      rep(i[2:0], 64'h1000 + i * 4);
      rd(8'h28, d);
      chk(d, {23'h0, i[2] & i[1] & !i[0], i[2], 39'h0});
      rd(8'h30, d);
      chk(d, 64'h1000 + i * 4);
    end
    #1 chk(irq, 1'b1);
    rd(8'h38, d);
    chk(d, 64'h4);
    wr(8'h40, 64'h4);
    #1 chk(irq, 1'b0);
    rd(8'h50, d);
    chk(d, 64'h0);
    rd(8'h40, d);
    chk(d, 64'h0);
    $display("profile test done");
  endtask : t_profile

  // ==========================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_basic;
    t_count;
    t_wrap;
    t_profile;
    test_done;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      test_done;
    end
  end
endmodule : perf_counter_profile_unit_tb
